// file: rtl/sioa_cfg.svh
// Register offsets, field positions, reset values and setting codes for the I/O allocation block
`ifndef SIOA_CFG_SVH
`define SIOA_CFG_SVH
// Register byte offsets
`define SIOA_OFS_IN_A    8'h00
`define SIOA_OFS_IN_B    8'h04
`define SIOA_OFS_IN_C    8'h08
`define SIOA_OFS_OUT_A   8'h0c
`define SIOA_OFS_OUT_B   8'h10
`define SIOA_OFS_OUT_C   8'h14
`define SIOA_OFS_INV     8'h18
`define SIOA_OFS_CTRL    8'h1c
`define SIOA_OFS_STAT    8'h20
`define SIOA_OFS_PINS    8'h24
// Reset values
`define SIOA_RST_IN_A    16'h1000
`define SIOA_RST_IN_B    16'h8802
`define SIOA_RST_IN_C    16'h6543
`define SIOA_RST_OUT_A   16'h0000
`define SIOA_RST_OUT_B   16'h0100
`define SIOA_RST_OUT_C   16'h0000
`define SIOA_RST_INV     3'h0
`define SIOA_RST_CTRL    1'h0
// Field positions of the four-bit setting digits
`define SIOA_POS_FWD_TRAVEL  12
`define SIOA_POS_REV_TRAVEL  0
`define SIOA_POS_FWD_FORCE   8
`define SIOA_POS_REV_FORCE   12
`define SIOA_POS_HOMING      0
`define SIOA_POS_LATCH_1     4
`define SIOA_POS_LATCH_2     8
`define SIOA_POS_LATCH_3     12
`define SIOA_POS_POS_DONE    0
`define SIOA_POS_SPD_MATCH   4
`define SIOA_POS_MOTION      8
`define SIOA_POS_FORCE_LIM   0
`define SIOA_POS_SPEED_LIM   4
`define SIOA_POS_BRAKE       8
`define SIOA_POS_NEAR        0
// Input setting codes
`define SIOA_CODE_ON         4'h7
`define SIOA_CODE_OFF        4'h8
`define SIOA_CODE_INV_BASE   4'h9
`define SIOA_CODE_LATCH_MIN  3'h4
// AXI responses
`define SIOA_RESP_OKAY       2'h0
`define SIOA_RESP_SLVERR     2'h2
`endif

// file: rtl/sioa_pkg.sv
// Types shared by the I/O allocation block
package sioa_pkg;
  // Motor current sequencer, Gray coded along blocked-enabling-running
  typedef enum logic [1:0] {
    SIOA_BB_BLOCKED  = 2'h0,
    SIOA_BB_ENABLING = 2'h1,
    SIOA_BB_RUNNING  = 2'h3
  } sioa_bb_state_t;
  // Control mode reported by the drive core
  typedef enum logic [1:0] {
    SIOA_MODE_POSITION = 2'h0,
    SIOA_MODE_SPEED    = 2'h1,
    SIOA_MODE_FORCE    = 2'h2
  } sioa_mode_t;
endpackage

// file: rtl/sioa_in_map.sv
// Decoder of one input function setting onto the synchronised input pins
`timescale 1ns/10ps
`default_nettype none
`include "sioa_cfg.svh"
module sioa_in_map
  import sioa_pkg::*;
#(
  parameter bit ACTIVE_LOW = 1'b0,  // Function is valid at low pin level by default
  parameter bit LATCH_ONLY = 1'b0   // Only the three latch-capable pins may be chosen
) (
  // Setting and pins
  input  wire logic [3:0] map_code,
  input  wire logic [6:0] pin_level,
  // Result
  output logic            func_level,
  output logic            code_invalid
);
  logic [3:0] sel;  // Pin index 0 for pin 13, 1..6 for pins 7..12
  logic       inv;  // Inverted polarity selected

  // Decode fixed levels, pin choice and polarity
  always_comb begin
    func_level   = 1'b0;
    code_invalid = 1'b0;
    inv          = (map_code >= `SIOA_CODE_INV_BASE);
    sel          = inv ? (map_code - `SIOA_CODE_INV_BASE) : map_code;
    if (map_code == `SIOA_CODE_ON) begin
      func_level = 1'b1;
    end else if (map_code == `SIOA_CODE_OFF) begin
      func_level = 1'b0;
    end else if (LATCH_ONLY && (sel[2:0] < `SIOA_CODE_LATCH_MIN)) begin
      // Pin 13 and pins 7 to 9 cannot latch; function stays inactive
      code_invalid = 1'b1;
    end else begin
      // Any number of functions may read the same pin level
      func_level = pin_level[sel[2:0]] ^ ACTIVE_LOW ^ inv;
    end
  end
endmodule
`default_nettype wire

// file: rtl/sioa_out_map.sv
// Router of output functions onto three output pairs with OR merge and inversion
`timescale 1ns/10ps
`default_nettype none
module sioa_out_map
  import sioa_pkg::*;
#(
  parameter int NFUNC = 7  // Number of routable output functions
) (
  // Settings
  input  wire logic [4*NFUNC-1:0] route_codes,
  input  wire logic [2:0]         pair_invert,
  // Function levels, already gated by mode validity
  input  wire logic [NFUNC-1:0]   func_active,
  // Pair levels
  output logic      [2:0]         pair_level
);
  genvar p;
  generate
    for (p = 0; p < 3; p++) begin : g_pair
      logic merged;  // OR of every function routed here
      // Code p+1 selects this pair, code 0 leaves a function unconnected
      always_comb begin
        merged = 1'b0;
        for (int f = 0; f < NFUNC; f++) begin
          if (route_codes[4*f +: 4] == 4'(p + 1)) begin
            merged = merged | func_active[f];
          end
        end
        pair_level[p] = merged ^ pair_invert[p];
      end
    end
  endgenerate
endmodule
`default_nettype wire

// file: rtl/sioa_top.sv
// Top of the sequence I/O allocation block with its AXI4-Lite register slave
`timescale 1ns/10ps
`default_nettype none
`include "sioa_cfg.svh"
module sioa_top
  import sioa_pkg::*;
#(
  parameter int ADDR_W = 8  // AXI address width
) (
  // Clock and reset
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // AXI4-Lite write address
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  // AXI4-Lite read
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // Physical inputs: bit 0 pin 13, bits 1..6 pins 7..12, 1 = circuit on
  input  wire logic [6:0]        sio_pin_in,
  input  wire logic              safety_block_in_a,
  input  wire logic              safety_block_in_b,
  // Drive core status feeding output functions
  input  wire logic [1:0]        control_mode,
  input  wire logic              position_done_flag,
  input  wire logic              speed_match_flag,
  input  wire logic              motion_detect_flag,
  input  wire logic              force_limited_flag,
  input  wire logic              speed_limited_flag,
  input  wire logic              brake_release_req,
  input  wire logic              near_target_flag,
  // Input functions towards the drive core
  output logic                   fwd_travel_inhibit,
  output logic                   rev_travel_inhibit,
  output logic                   fwd_force_limit_in,
  output logic                   rev_force_limit_in,
  output logic                   homing_slowdown_in,
  output logic                   latch_trigger_1,
  output logic                   latch_trigger_2,
  output logic                   latch_trigger_3,
  // Output pairs, bit 0 first pair
  output logic [2:0]             sio_pair_out,
  // Safety and power stage
  output logic                   motor_current_enable,
  output logic                   safety_monitor_out
);
  localparam int NIN  = 8;  // Input functions
  localparam int NOUT = 7;  // Output functions
  // Default polarity per input function: overtravel high, others low
  localparam logic [NIN-1:0] IN_ACT_LOW = 8'hfc;
  // Functions restricted to latch-capable pins
  localparam logic [NIN-1:0] IN_LATCH   = 8'he0;

  // Setting registers
  logic [15:0] in_map_a_q;    // input_map_setting_a
  logic [15:0] in_map_b_q;    // input_map_setting_b
  logic [15:0] in_map_c_q;    // input_map_setting_c
  logic [15:0] out_map_a_q;   // output_map_setting_a
  logic [15:0] out_map_b_q;   // output_map_setting_b
  logic [15:0] out_map_c_q;   // output_map_setting_c
  logic [2:0]  out_inv_q;     // output_invert_setting
  logic        servo_on_q;    // Software request for motor current
  // Synchronisers; first stages are read only by second stages
  logic [8:0]  sync1_q;
  logic [8:0]  sync2_q;
  // Decoded functions
  logic [4*NIN-1:0]  in_codes;
  logic [NIN-1:0]    in_func;
  logic [NIN-1:0]    in_bad;
  logic [NIN-1:0]    in_func_q;
  logic [4*NOUT-1:0] out_codes;
  logic [NOUT-1:0]   out_func;
  logic [2:0]        pair_lvl;
  logic [2:0]        pair_q;
  // Safety sequencer
  sioa_bb_state_t    bb_state_q;
  logic              both_on;
  logic              monitor_q;
  // AXI slave state
  logic              awready_q;
  logic              wready_q;
  logic              aw_have_q;
  logic              w_have_q;
  logic [ADDR_W-1:0] aw_addr_q;
  logic [31:0]       w_data_q;
  logic [3:0]        w_strb_q;
  logic              bvalid_q;
  logic [1:0]        bresp_q;
  logic              arready_q;
  logic              rvalid_q;
  logic [31:0]       rdata_q;
  logic [1:0]        rresp_q;
  logic              wr_fire;
  logic [7:0]        wr_ofs;
  logic [7:0]        rd_ofs;
  logic [31:0]       rd_word;
  logic              rd_hit;

  // Merge a write into a 16-bit register honouring byte strobes
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] dat,
                                          input logic [3:0] strb);
    logic [15:0] r;
    r = old;
    if (strb[0]) begin
      r[7:0] = dat[7:0];
    end
    if (strb[1]) begin
      r[15:8] = dat[15:8];
    end
    return r;
  endfunction

  // Two-stage synchroniser on pins and safety inputs
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1_q <= 9'h000;
      sync2_q <= 9'h000;
    end else begin
      sync1_q <= {safety_block_in_b, safety_block_in_a, sio_pin_in};
      sync2_q <= sync1_q;
    end
  end

  // Gather input setting digits in function order
  assign in_codes = {in_map_c_q[`SIOA_POS_LATCH_3 +: 4], in_map_c_q[`SIOA_POS_LATCH_2 +: 4],
                     in_map_c_q[`SIOA_POS_LATCH_1 +: 4], in_map_c_q[`SIOA_POS_HOMING +: 4],
                     in_map_b_q[`SIOA_POS_REV_FORCE +: 4], in_map_b_q[`SIOA_POS_FWD_FORCE +: 4],
                     in_map_b_q[`SIOA_POS_REV_TRAVEL +: 4], in_map_a_q[`SIOA_POS_FWD_TRAVEL +: 4]};

  // One decoder per input function, all reading the same synced pins
  genvar gi;
  generate
    for (gi = 0; gi < NIN; gi++) begin : g_in
      sioa_in_map #(
        .ACTIVE_LOW (IN_ACT_LOW[gi]),
        .LATCH_ONLY (IN_LATCH[gi])
      ) u_in (
        .map_code     (in_codes[4*gi +: 4]),
        .pin_level    (sync2_q[6:0]),
        .func_level   (in_func[gi]),
        .code_invalid (in_bad[gi])
      );
    end
  endgenerate

  // Register input functions so outputs come from flip-flops
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      in_func_q <= '0;
    end else begin
      in_func_q <= in_func;
    end
  end
  assign fwd_travel_inhibit = in_func_q[0];
  assign rev_travel_inhibit = in_func_q[1];
  assign fwd_force_limit_in = in_func_q[2];
  assign rev_force_limit_in = in_func_q[3];
  assign homing_slowdown_in = in_func_q[4];
  assign latch_trigger_1    = in_func_q[5];
  assign latch_trigger_2    = in_func_q[6];
  assign latch_trigger_3    = in_func_q[7];

  // Output functions, masked where the mode cannot detect them
  assign out_func = {near_target_flag, brake_release_req, speed_limited_flag, force_limited_flag,
                     motion_detect_flag,
                     speed_match_flag & (control_mode == SIOA_MODE_SPEED),
                     position_done_flag & (control_mode == SIOA_MODE_POSITION)};
  assign out_codes = {out_map_c_q[`SIOA_POS_NEAR +: 4], out_map_b_q[`SIOA_POS_BRAKE +: 4],
                      out_map_b_q[`SIOA_POS_SPEED_LIM +: 4], out_map_b_q[`SIOA_POS_FORCE_LIM +: 4],
                      out_map_a_q[`SIOA_POS_MOTION +: 4], out_map_a_q[`SIOA_POS_SPD_MATCH +: 4],
                      out_map_a_q[`SIOA_POS_POS_DONE +: 4]};

  sioa_out_map #(
    .NFUNC (NOUT)
  ) u_out (
    .route_codes (out_codes),
    .pair_invert (out_inv_q),
    .func_active (out_func),
    .pair_level  (pair_lvl)
  );

  // Output pair flops
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pair_q <= 3'h0;
    end else begin
      pair_q <= pair_lvl;
    end
  end
  assign sio_pair_out = pair_q;

  // Both hard-wired safety inputs on after synchronisation
  assign both_on = sync2_q[7] & sync2_q[8];

  // Motor current sequencer: blocking is immediate, enabling takes a cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bb_state_q <= SIOA_BB_BLOCKED;
    end else begin
      case (bb_state_q)
        SIOA_BB_BLOCKED: begin
          if (both_on && servo_on_q) begin
            bb_state_q <= SIOA_BB_ENABLING;
          end
        end
        SIOA_BB_ENABLING: begin
          // One settle cycle so a glitchy release cannot pulse the stage
          bb_state_q <= (both_on && servo_on_q) ? SIOA_BB_RUNNING : SIOA_BB_BLOCKED;
        end
        SIOA_BB_RUNNING: begin
          if (!both_on || !servo_on_q) begin
            bb_state_q <= SIOA_BB_BLOCKED;
          end
        end
        default: begin
          bb_state_q <= SIOA_BB_BLOCKED;
        end
      endcase
    end
  end
  assign motor_current_enable = bb_state_q[1]; // Set only in RUNNING

  // Monitor output: both inputs on and current really cut
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      monitor_q <= 1'b0;
    end else begin
      monitor_q <= both_on && (bb_state_q == SIOA_BB_BLOCKED);
    end
  end
  assign safety_monitor_out = monitor_q;

  // Write address channel: one outstanding write at a time
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_q <= 1'b1;
      aw_have_q <= 1'b0;
      aw_addr_q <= '0;
    end else if (awready_q && s_axi_awvalid) begin
      awready_q <= 1'b0;
      aw_have_q <= 1'b1;
      aw_addr_q <= s_axi_awaddr;
    end else if (wr_fire) begin
      aw_have_q <= 1'b0;
    end else if (bvalid_q && s_axi_bready) begin
      awready_q <= 1'b1;
    end
  end

  // Write data channel, accepted independently of the address
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wready_q <= 1'b1;
      w_have_q <= 1'b0;
      w_data_q <= 32'h0;
      w_strb_q <= 4'h0;
    end else if (wready_q && s_axi_wvalid) begin
      wready_q <= 1'b0;
      w_have_q <= 1'b1;
      w_data_q <= s_axi_wdata;
      w_strb_q <= s_axi_wstrb;
    end else if (wr_fire) begin
      w_have_q <= 1'b0;
    end else if (bvalid_q && s_axi_bready) begin
      wready_q <= 1'b1;
    end
  end

  assign wr_fire = aw_have_q && w_have_q && !bvalid_q;
  assign wr_ofs  = 8'({aw_addr_q[ADDR_W-1:2], 2'b00});

  // Write response; unmapped or read-only offsets answer SLVERR
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q  <= `SIOA_RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_q <= 1'b1;
      bresp_q  <= (wr_ofs <= `SIOA_OFS_CTRL) ? `SIOA_RESP_OKAY : `SIOA_RESP_SLVERR;
    end else if (bvalid_q && s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  // Setting registers written by software
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      in_map_a_q  <= `SIOA_RST_IN_A;
      in_map_b_q  <= `SIOA_RST_IN_B;
      in_map_c_q  <= `SIOA_RST_IN_C;
      out_map_a_q <= `SIOA_RST_OUT_A;
      out_map_b_q <= `SIOA_RST_OUT_B;
      out_map_c_q <= `SIOA_RST_OUT_C;
      out_inv_q   <= `SIOA_RST_INV;
      servo_on_q  <= `SIOA_RST_CTRL;
    end else if (wr_fire) begin
      case (wr_ofs)
        `SIOA_OFS_IN_A:  in_map_a_q  <= merge16(in_map_a_q, w_data_q, w_strb_q);
        `SIOA_OFS_IN_B:  in_map_b_q  <= merge16(in_map_b_q, w_data_q, w_strb_q);
        `SIOA_OFS_IN_C:  in_map_c_q  <= merge16(in_map_c_q, w_data_q, w_strb_q);
        `SIOA_OFS_OUT_A: out_map_a_q <= merge16(out_map_a_q, w_data_q, w_strb_q);
        `SIOA_OFS_OUT_B: out_map_b_q <= merge16(out_map_b_q, w_data_q, w_strb_q);
        `SIOA_OFS_OUT_C: out_map_c_q <= merge16(out_map_c_q, w_data_q, w_strb_q);
        `SIOA_OFS_INV: begin
          if (w_strb_q[0]) begin
            out_inv_q <= w_data_q[2:0];
          end
        end
        `SIOA_OFS_CTRL: begin
          if (w_strb_q[0]) begin
            servo_on_q <= w_data_q[0];
          end
        end
        default: begin
          // Unmapped or read-only: nothing stored
        end
      endcase
    end
  end

  // Read decode; status words show live decoded state
  assign rd_ofs = 8'({s_axi_araddr[ADDR_W-1:2], 2'b00});
  always_comb begin
    rd_word = 32'h0;
    rd_hit  = 1'b1;
    case (rd_ofs)
      `SIOA_OFS_IN_A:  rd_word = {16'h0, in_map_a_q};
      `SIOA_OFS_IN_B:  rd_word = {16'h0, in_map_b_q};
      `SIOA_OFS_IN_C:  rd_word = {16'h0, in_map_c_q};
      `SIOA_OFS_OUT_A: rd_word = {16'h0, out_map_a_q};
      `SIOA_OFS_OUT_B: rd_word = {16'h0, out_map_b_q};
      `SIOA_OFS_OUT_C: rd_word = {16'h0, out_map_c_q};
      `SIOA_OFS_INV:   rd_word = {29'h0, out_inv_q};
      `SIOA_OFS_CTRL:  rd_word = {31'h0, servo_on_q};
      `SIOA_OFS_STAT:  rd_word = {13'h0, pair_q, 1'b0, bb_state_q, monitor_q,
                                  motor_current_enable, in_bad[7:5], in_func_q};
      `SIOA_OFS_PINS:  rd_word = {23'h0, sync2_q};
      default:         rd_hit  = 1'b0;
    endcase
  end

  // Read channel: capture on address handshake, hold until taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b1;
      rvalid_q  <= 1'b0;
      rdata_q   <= 32'h0;
      rresp_q   <= `SIOA_RESP_OKAY;
    end else if (arready_q && s_axi_arvalid) begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b1;
      rdata_q   <= rd_word;
      rresp_q   <= rd_hit ? `SIOA_RESP_OKAY : `SIOA_RESP_SLVERR;
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_q  <= 1'b0;
      arready_q <= 1'b1;
    end
  end

  assign s_axi_awready = awready_q;
  assign s_axi_wready  = wready_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;
endmodule
`default_nettype wire

// file: test/sioa_far_model.sv
// Host sequence I/O and safety devices driving the block's pins
`timescale 1ns/10ps
`default_nettype none
module sioa_far_model (
  // Clock of the drive
  input  wire logic       aclk,
  // Levels requested by the test
  input  wire logic [6:0] pin_req,
  input  wire logic [1:0] safe_req,
  // Contacts towards the block
  output logic      [6:0] sio_pin_in,
  output logic            safety_block_in_a,
  output logic            safety_block_in_b
);
  // Contacts follow the request at once; the block's own synchroniser absorbs any skew
  assign sio_pin_in        = pin_req;
  assign safety_block_in_a = safe_req[1];
  assign safety_block_in_b = safe_req[0];
endmodule
`default_nettype wire

// file: test/sioa_top_chk.sv
// Checker of safety, synchroniser and bus hand-off timing at the block's ports
`timescale 1ns/10ps
`default_nettype none
module sioa_top_chk (
  // Clock and reset
  input  wire logic       aclk,
  input  wire logic       aresetn,
  // Watched inputs
  input  wire logic       safety_block_in_a,
  input  wire logic       safety_block_in_b,
  input  wire logic [6:0] sio_pin_in,
  // Watched outputs
  input  wire logic       s_axi_bvalid,
  input  wire logic       s_axi_awready,
  input  wire logic       s_axi_rvalid,
  input  wire logic       s_axi_arready,
  input  wire logic       fwd_travel_inhibit,
  input  wire logic       motor_current_enable,
  input  wire logic       safety_monitor_out
);
  // One clock domain, checks paused in reset
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_off_blocks_current: assert property (
    (!safety_block_in_a || !safety_block_in_b) [*4] |-> !motor_current_enable)
    else $error("Current on while a safety input is off");
  a_enable_needs_both: assert property (
    $rose(motor_current_enable) |-> $past(safety_block_in_a, 3) && $past(safety_block_in_b, 3))
    else $error("Current enabled without both safety inputs");
  a_monitor_needs_both: assert property (
    safety_monitor_out |-> $past(safety_block_in_a, 3) && $past(safety_block_in_b, 3))
    else $error("Monitor on without both safety inputs");
  a_monitor_not_run: assert property (motor_current_enable |-> !safety_monitor_out)
    else $error("Monitor on while current flows");
  // A pin change needs the two sync stages plus the output flop
  a_pin_sync_delay: assert property (
    $changed(fwd_travel_inhibit) && !$past(s_axi_bvalid) && !$past(s_axi_bvalid, 2)
    |-> $past(sio_pin_in, 3) != $past(sio_pin_in, 4))
    else $error("Function moved without a pin change three edges earlier");
  a_pin_quiet_hold: assert property (
    ($stable(sio_pin_in) && !s_axi_bvalid) [*5] |-> $stable(fwd_travel_inhibit))
    else $error("Function moved with quiet pins and settings");
  a_aw_held_off: assert property (s_axi_bvalid |-> !s_axi_awready)
    else $error("Write address accepted before response taken");
  a_ar_held_off: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("Read address accepted before data taken");
endmodule
bind sioa_top sioa_top_chk i_sioa_top_chk (.aclk, .aresetn, .safety_block_in_a, .safety_block_in_b, .sio_pin_in,
  .s_axi_bvalid, .s_axi_awready, .s_axi_rvalid, .s_axi_arready, .fwd_travel_inhibit, .motor_current_enable,
  .safety_monitor_out);
`default_nettype wire

// file: test/testbench.sv
// Self-checking bench for the sequence I/O allocation block
`timescale 1ns/10ps
`default_nettype none
`include "sioa_cfg.svh"
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin fails++; \
  $display("Error t=%0t got %h exp %h", $time, g, e); end end
module testbench;
  // Responses expected on the bus
  localparam logic [1:0] OK = `SIOA_RESP_OKAY;
  localparam logic [1:0] ERR = `SIOA_RESP_SLVERR;
  // Stimulus, every input defined from time zero
  logic        aclk = 1'b0, aresetn = 1'b0, s_axi_rready = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
  logic [6:0]  pin_req = 7'h00;
  logic [1:0]  safe_req = 2'h3, control_mode = 2'h0;
  logic        position_done_flag = 1'b0, speed_match_flag = 1'b0, motion_detect_flag = 1'b0;
  logic        force_limited_flag = 1'b0, speed_limited_flag = 1'b0, brake_release_req = 1'b0, near_target_flag = 1'b0;
  // Design answers
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic [6:0]  sio_pin_in;
  logic [2:0]  sio_pair_out;
  logic        safety_block_in_a, safety_block_in_b, fwd_travel_inhibit, rev_travel_inhibit, fwd_force_limit_in;
  logic        rev_force_limit_in, homing_slowdown_in, latch_trigger_1, latch_trigger_2, latch_trigger_3;
  logic        motor_current_enable, safety_monitor_out;
  int          fails = 0, check_count = 0;
  logic [15:0] rst_val [8] = '{`SIOA_RST_IN_A, `SIOA_RST_IN_B, `SIOA_RST_IN_C, `SIOA_RST_OUT_A, `SIOA_RST_OUT_B,
                               `SIOA_RST_OUT_C, `SIOA_RST_INV, `SIOA_RST_CTRL};
  sioa_far_model i_sioa_far_model (.aclk, .pin_req, .safe_req, .sio_pin_in, .safety_block_in_a, .safety_block_in_b);
  sioa_top i_sioa_top (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .sio_pin_in, .safety_block_in_a,
    .safety_block_in_b, .control_mode, .position_done_flag, .speed_match_flag, .motion_detect_flag,
    .force_limited_flag, .speed_limited_flag, .brake_release_req, .near_target_flag, .fwd_travel_inhibit,
    .rev_travel_inhibit, .fwd_force_limit_in, .rev_force_limit_in, .homing_slowdown_in, .latch_trigger_1,
    .latch_trigger_2, .latch_trigger_3, .sio_pair_out, .motor_current_enable, .safety_monitor_out);
  // 100 MHz clock
  initial forever #5 aclk = ~aclk;
  // Expected input function level; lo marks a function active at low pin level
  function automatic logic fexp(logic [3:0] c, logic [6:0] p, logic lo, logic lat);
    int i;
    i = (c < 4'h7) ? int'(c) : int'(c) - 9;
    if (c == 4'h7) return 1'b1;
    if (c == 4'h8) return 1'b0;
    if (lat && i < 4) return 1'b0;
    return p[i] ^ (c > 4'h8) ^ lo;
  endfunction
  task automatic tick(input int n);
    repeat (n) @(posedge aclk);
  endtask
  // Write: address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    `CHK(s_axi_bresp, er)
  endtask
  // Read with a mask, since status mixes fields
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m, input logic [1:0] er);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    `CHK(s_axi_rdata & m, e)
    `CHK(s_axi_rresp, er)
  endtask
  task automatic finish_test();
    $display("Checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    for (int i = 0; i < 8; i++) rd(8'(4 * i), 32'(rst_val[i]), 32'hffff, OK);
    rd(8'h28, 32'h0, 32'hffffffff, ERR);
    wr(`SIOA_OFS_STAT, 32'h1, ERR);
    $display("Test registers done");
    // Every code on travel and latch 1, two opposite pin patterns
    for (int c = 0; c < 16; c++) begin
      wr(`SIOA_OFS_IN_A, 32'(c) << 12, OK);
      wr(`SIOA_OFS_IN_C, 32'h6503 | (32'(c) << 4), OK);
      for (int k = 0; k < 2; k++) begin
        pin_req <= k ? 7'h2a : 7'h55;
        tick(5);
        `CHK(fwd_travel_inhibit, fexp(4'(c), pin_req, 1'b0, 1'b0))
        `CHK(latch_trigger_1, fexp(4'(c), pin_req, 1'b1, 1'b1))
        `CHK({homing_slowdown_in, latch_trigger_2, latch_trigger_3}, k ? 3'b001 : 3'b110)
        rd(`SIOA_OFS_STAT, (c < 4 || (c > 8 && c < 13)) ? 32'h100 : 32'h0, 32'h100, OK);
      end
    end
    // Three functions on one pin
    wr(`SIOA_OFS_IN_A, 32'h1000, OK);
    wr(`SIOA_OFS_IN_B, 32'h0101, OK);
    for (int k = 0; k < 2; k++) begin
      pin_req <= k ? 7'h00 : 7'h02;
      tick(5);
      `CHK({fwd_travel_inhibit, rev_travel_inhibit, fwd_force_limit_in}, k ? 3'b001 : 3'b110)
      `CHK(rev_force_limit_in, 1'b1)
    end
    $display("Test inputs done");
    motion_detect_flag <= 1'b1;
    for (int c = 0; c < 5; c++) begin
      wr(`SIOA_OFS_OUT_A, 32'(c) << 8, OK);
      tick(2);
      `CHK(sio_pair_out, (c > 0 && c < 4) ? 3'(1 << (c - 1)) : 3'h0)
    end
    // Motion and brake share pair one
    wr(`SIOA_OFS_OUT_A, 32'h0100, OK);
    for (int k = 0; k < 4; k++) begin
      {motion_detect_flag, brake_release_req} <= 2'(k);
      tick(2);
      `CHK(sio_pair_out, 3'(k != 0))
    end
    {motion_detect_flag, brake_release_req} <= 2'h0;
    wr(`SIOA_OFS_INV, 32'h5, OK);
    tick(2);
    `CHK(sio_pair_out, 3'h5)
    wr(`SIOA_OFS_INV, 32'h0, OK);
    // Mode-dependent flags on pair two
    position_done_flag <= 1'b1;
    speed_match_flag <= 1'b1;
    for (int m = 0; m < 2; m++) begin
      wr(`SIOA_OFS_OUT_A, m ? 32'h0020 : 32'h0002, OK);
      for (int k = 0; k < 2; k++) begin
        control_mode <= 2'(k ? m : 1 - m);
        tick(2);
        `CHK(sio_pair_out, k ? 3'h2 : 3'h0)
      end
    end
    $display("Test outputs done");
    // Safety inputs with the servo on, then off
    wr(`SIOA_OFS_CTRL, 32'h1, OK);
    for (int k = 0; k < 3; k++) begin
      safe_req <= (k == 0) ? 2'h3 : 2'(k);
      tick(8);
      `CHK({motor_current_enable, safety_monitor_out}, (k == 0) ? 2'b10 : 2'b00)
    end
    safe_req <= 2'h3;
    wr(`SIOA_OFS_CTRL, 32'h0, OK);
    tick(8);
    `CHK({motor_current_enable, safety_monitor_out}, 2'b01)
    $display("Test safety done");
    finish_test();
  end
  // Watchdog well beyond the few hundred cycles the tests need
  initial begin
    #200us;
    fails++;
    finish_test();
  end
endmodule
`default_nettype wire
